// ---- design/aer_cfg.svh ----
// constants for the error capability header and uncorrectable flag register
// Functional notes
// - header bits 15:0 read as fixed capability identifier 0001h
// - header bits 19:16 read as fixed version 1h
// - header bits 31:20 hold next pointer, 000h or above 0FFh
// - header sits at offset 00h, flag register at offset 04h
// - hardware sets a flag on error; writing 1 clears, writing 0 keeps
// - unimplemented flag positions read 0 and ignore writes
// - optional errors present alike in status, mask and severity or absent
// - bit 0 is obsolete; reads undefined, writes have no effect
// - bit 4 link protocol violation flag always present, default 0
// - bit 5 optional link loss flag, default 0
// - bits 12, 18, 20 poisoned, malformed, unsupported flags always present
// - bit 16 unmatched completion flag always present, default 0
// - bit 13 optional flow control violation flag, default 0
// - bit 15 optional completer abort flag, default 0
// - bit 17 optional receive overflow flag, default 0
// - bit 19 optional end-to-end crc failure flag, default 0
// - bit 14 completion timeout; hardwired 0 on switch port without own requests
`ifndef AER_CFG_SVH
`define AER_CFG_SVH
`define CAP_ID_VALUE 16'h0001
`define CAP_VERSION_VALUE 4'h1
`define NEXT_PTR_END 12'h000
`define NEXT_PTR_MIN 12'h0FF
`define HEADER_OFFSET 10'h000
`define FLAGS_OFFSET 10'h001
`define BIT_OBSOLETE 0
`define BIT_LINK_PROTOCOL 4
`define BIT_LINK_LOSS 5
`define BIT_POISONED 12
`define BIT_FLOW_CONTROL 13
`define BIT_CPL_TIMEOUT 14
`define BIT_COMPLETER_ABORT 15
`define BIT_UNEXPECTED_CPL 16
`define BIT_RX_OVERFLOW 17
`define BIT_MALFORMED 18
`define BIT_CRC_FAIL 19
`define BIT_UNSUPPORTED 20
`define FLAG_RESET 1'h0
`define ZERO_WORD 32'h0000_0000
`endif

// ---- design/aer_pkg.sv ----
// types shared by the error capability block
package aer_pkg;
  typedef logic [31:0] word_type;
  typedef logic [9:0] dword_index_type;
endpackage

// ---- design/sticky_flag.sv ----
// one sticky write-one-to-clear flag, or a hardwired zero
`timescale 1ns/1ps
`default_nettype none
`include "aer_cfg.svh"
module sticky_flag #(
  parameter bit PRESENT = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic set_pulse,
  input wire logic clear_pulse,
  output logic flag
);
  logic state;
  logic next_state;

  always_comb begin
    // set wins over a clear in the same cycle
    next_state = set_pulse | (state & ~clear_pulse);
  end

  // only power-on reset reaches this flop
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= `FLAG_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign flag = PRESENT ? state : 1'b0;
endmodule
`default_nettype wire

// ---- design/header_word.sv ----
// read-only capability header word
`timescale 1ns/1ps
`default_nettype none
`include "aer_cfg.svh"
module header_word
  import aer_pkg::*;
#(
  parameter logic [11:0] NEXT_PTR = `NEXT_PTR_END
) (
  output word_type value
);
  assign value = {NEXT_PTR, `CAP_VERSION_VALUE, `CAP_ID_VALUE};
endmodule
`default_nettype wire

// ---- design/adv_error_cap_uncorr_status.sv ----
// advanced error capability header and uncorrectable error flag register
`timescale 1ns/1ps
`default_nettype none
`include "aer_cfg.svh"
module adv_error_cap_uncorr_status
  import aer_pkg::*;
#(
  parameter logic [11:0] NEXT_PTR = `NEXT_PTR_END,
  parameter bit HAS_LINK_LOSS = 1'b1,
  parameter bit HAS_FLOW_CONTROL = 1'b1,
  parameter bit HAS_CPL_TIMEOUT = 1'b1,
  parameter bit HAS_COMPLETER_ABORT = 1'b1,
  parameter bit HAS_RX_OVERFLOW = 1'b1,
  parameter bit HAS_CRC_FAIL = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_read,
  input wire logic cfg_write,
  input wire dword_index_type cfg_index,
  input wire word_type cfg_write_data,
  input wire logic [3:0] cfg_byte_enable,
  output word_type cfg_read_data,
  output logic cfg_read_valid,
  input wire logic err_link_protocol,
  input wire logic err_link_loss,
  input wire logic err_poisoned,
  input wire logic err_flow_control,
  input wire logic err_cpl_timeout,
  input wire logic err_completer_abort,
  input wire logic err_unexpected_cpl,
  input wire logic err_rx_overflow,
  input wire logic err_malformed,
  input wire logic err_crc_fail,
  input wire logic err_unsupported,
  output word_type error_flags
);
  // next pointer must end the list or lie past the legacy space
  localparam bit PTR_OK = (NEXT_PTR == `NEXT_PTR_END) || (NEXT_PTR > `NEXT_PTR_MIN);
  // an illegal pointer is dropped so software never walks off the list
  localparam logic [11:0] PTR_USED = PTR_OK ? {NEXT_PTR[11:2], 2'b00} : `NEXT_PTR_END;

  // positions that own a flag slot, optional ones included
  localparam word_type SLOT_MASK =
    (word_type'(1'b1) << `BIT_LINK_PROTOCOL) |
    (word_type'(1'b1) << `BIT_LINK_LOSS) |
    (word_type'(1'b1) << `BIT_POISONED) |
    (word_type'(1'b1) << `BIT_FLOW_CONTROL) |
    (word_type'(1'b1) << `BIT_CPL_TIMEOUT) |
    (word_type'(1'b1) << `BIT_COMPLETER_ABORT) |
    (word_type'(1'b1) << `BIT_UNEXPECTED_CPL) |
    (word_type'(1'b1) << `BIT_RX_OVERFLOW) |
    (word_type'(1'b1) << `BIT_MALFORMED) |
    (word_type'(1'b1) << `BIT_CRC_FAIL) |
    (word_type'(1'b1) << `BIT_UNSUPPORTED);

  // one presence set, meant to be shared with mask and severity words
  localparam word_type PRESENT_MASK =
    (word_type'(1'b1) << `BIT_LINK_PROTOCOL) |
    (word_type'(HAS_LINK_LOSS) << `BIT_LINK_LOSS) |
    (word_type'(1'b1) << `BIT_POISONED) |
    (word_type'(HAS_FLOW_CONTROL) << `BIT_FLOW_CONTROL) |
    (word_type'(HAS_CPL_TIMEOUT) << `BIT_CPL_TIMEOUT) |
    (word_type'(HAS_COMPLETER_ABORT) << `BIT_COMPLETER_ABORT) |
    (word_type'(1'b1) << `BIT_UNEXPECTED_CPL) |
    (word_type'(HAS_RX_OVERFLOW) << `BIT_RX_OVERFLOW) |
    (word_type'(1'b1) << `BIT_MALFORMED) |
    (word_type'(HAS_CRC_FAIL) << `BIT_CRC_FAIL) |
    (word_type'(1'b1) << `BIT_UNSUPPORTED);

  word_type header_value;
  word_type set_vec;
  word_type byte_mask;
  word_type clear_vec;
  wire word_type flags;

  logic header_hit;
  logic flags_hit;
  logic read_header;
  logic read_flags;
  logic flag_write;

  word_type next_read_data;
  logic next_read_valid;
  word_type read_data;
  logic read_valid;

  header_word #(
    .NEXT_PTR(PTR_USED)
  ) u_header (
    .value(header_value)
  );

  // word decode shared by the read and write paths
  always_comb begin
    header_hit = (cfg_index == `HEADER_OFFSET);
    flags_hit = (cfg_index == `FLAGS_OFFSET);
    read_header = cfg_read && header_hit;
    read_flags = cfg_read && flags_hit;
    flag_write = cfg_write && flags_hit;
  end

  // detector pulses lined up with their register bits
  always_comb begin
    set_vec = `ZERO_WORD;
    set_vec[`BIT_LINK_PROTOCOL] = err_link_protocol;
    set_vec[`BIT_LINK_LOSS] = err_link_loss;
    set_vec[`BIT_POISONED] = err_poisoned;
    set_vec[`BIT_FLOW_CONTROL] = err_flow_control;
    set_vec[`BIT_CPL_TIMEOUT] = err_cpl_timeout;
    set_vec[`BIT_COMPLETER_ABORT] = err_completer_abort;
    set_vec[`BIT_UNEXPECTED_CPL] = err_unexpected_cpl;
    set_vec[`BIT_RX_OVERFLOW] = err_rx_overflow;
    set_vec[`BIT_MALFORMED] = err_malformed;
    set_vec[`BIT_CRC_FAIL] = err_crc_fail;
    set_vec[`BIT_UNSUPPORTED] = err_unsupported;
    // absent detectors never reach storage, so those flops stay quiet
    set_vec = set_vec & PRESENT_MASK;
  end

  always_comb begin
    byte_mask = {{8{cfg_byte_enable[3]}}, {8{cfg_byte_enable[2]}},
                 {8{cfg_byte_enable[1]}}, {8{cfg_byte_enable[0]}}};
    // header and unmapped writes clear nothing
    clear_vec = flag_write ? (cfg_write_data & byte_mask) : `ZERO_WORD;
    // bit 0 holds no state, so a write there has nothing to clear
    clear_vec[`BIT_OBSOLETE] = 1'b0;
  end

  // link protocol violation, always present
  sticky_flag #(
    .PRESENT(PRESENT_MASK[`BIT_LINK_PROTOCOL])
  ) u_link_protocol (
    .clk(clk),
    .reset(reset),
    .set_pulse(set_vec[`BIT_LINK_PROTOCOL]),
    .clear_pulse(clear_vec[`BIT_LINK_PROTOCOL]),
    .flag(flags[`BIT_LINK_PROTOCOL])
  );

  // link loss, optional
  sticky_flag #(
    .PRESENT(PRESENT_MASK[`BIT_LINK_LOSS])
  ) u_link_loss (
    .clk(clk),
    .reset(reset),
    .set_pulse(set_vec[`BIT_LINK_LOSS]),
    .clear_pulse(clear_vec[`BIT_LINK_LOSS]),
    .flag(flags[`BIT_LINK_LOSS])
  );

  // poisoned packet, always present
  sticky_flag #(
    .PRESENT(PRESENT_MASK[`BIT_POISONED])
  ) u_poisoned (
    .clk(clk),
    .reset(reset),
    .set_pulse(set_vec[`BIT_POISONED]),
    .clear_pulse(clear_vec[`BIT_POISONED]),
    .flag(flags[`BIT_POISONED])
  );

  // flow control violation, optional
  sticky_flag #(
    .PRESENT(PRESENT_MASK[`BIT_FLOW_CONTROL])
  ) u_flow_control (
    .clk(clk),
    .reset(reset),
    .set_pulse(set_vec[`BIT_FLOW_CONTROL]),
    .clear_pulse(clear_vec[`BIT_FLOW_CONTROL]),
    .flag(flags[`BIT_FLOW_CONTROL])
  );

  // completion timeout, tied off on a switch port without own requests
  sticky_flag #(
    .PRESENT(PRESENT_MASK[`BIT_CPL_TIMEOUT])
  ) u_cpl_timeout (
    .clk(clk),
    .reset(reset),
    .set_pulse(set_vec[`BIT_CPL_TIMEOUT]),
    .clear_pulse(clear_vec[`BIT_CPL_TIMEOUT]),
    .flag(flags[`BIT_CPL_TIMEOUT])
  );

  // completer abort, optional
  sticky_flag #(
    .PRESENT(PRESENT_MASK[`BIT_COMPLETER_ABORT])
  ) u_completer_abort (
    .clk(clk),
    .reset(reset),
    .set_pulse(set_vec[`BIT_COMPLETER_ABORT]),
    .clear_pulse(clear_vec[`BIT_COMPLETER_ABORT]),
    .flag(flags[`BIT_COMPLETER_ABORT])
  );

  // completion with no outstanding request, always present
  sticky_flag #(
    .PRESENT(PRESENT_MASK[`BIT_UNEXPECTED_CPL])
  ) u_unexpected_cpl (
    .clk(clk),
    .reset(reset),
    .set_pulse(set_vec[`BIT_UNEXPECTED_CPL]),
    .clear_pulse(clear_vec[`BIT_UNEXPECTED_CPL]),
    .flag(flags[`BIT_UNEXPECTED_CPL])
  );

  // receive buffer overflow, optional
  sticky_flag #(
    .PRESENT(PRESENT_MASK[`BIT_RX_OVERFLOW])
  ) u_rx_overflow (
    .clk(clk),
    .reset(reset),
    .set_pulse(set_vec[`BIT_RX_OVERFLOW]),
    .clear_pulse(clear_vec[`BIT_RX_OVERFLOW]),
    .flag(flags[`BIT_RX_OVERFLOW])
  );

  // malformed packet, always present
  sticky_flag #(
    .PRESENT(PRESENT_MASK[`BIT_MALFORMED])
  ) u_malformed (
    .clk(clk),
    .reset(reset),
    .set_pulse(set_vec[`BIT_MALFORMED]),
    .clear_pulse(clear_vec[`BIT_MALFORMED]),
    .flag(flags[`BIT_MALFORMED])
  );

  // end-to-end crc failure, optional
  sticky_flag #(
    .PRESENT(PRESENT_MASK[`BIT_CRC_FAIL])
  ) u_crc_fail (
    .clk(clk),
    .reset(reset),
    .set_pulse(set_vec[`BIT_CRC_FAIL]),
    .clear_pulse(clear_vec[`BIT_CRC_FAIL]),
    .flag(flags[`BIT_CRC_FAIL])
  );

  // unsupported request, always present
  sticky_flag #(
    .PRESENT(PRESENT_MASK[`BIT_UNSUPPORTED])
  ) u_unsupported (
    .clk(clk),
    .reset(reset),
    .set_pulse(set_vec[`BIT_UNSUPPORTED]),
    .clear_pulse(clear_vec[`BIT_UNSUPPORTED]),
    .flag(flags[`BIT_UNSUPPORTED])
  );

  // positions without a slot read as zero and ignore writes
  for (genvar k = 0; k < $bits(word_type); k++) begin : g_unused
    if (!SLOT_MASK[k]) begin : g_zero
      assign flags[k] = 1'b0;
    end
  end

  always_comb begin
    next_read_valid = cfg_read;
    next_read_data = `ZERO_WORD;
    if (read_header) begin
      next_read_data = header_value;
    end else if (read_flags) begin
      next_read_data = flags;
    end else begin
      // unmapped words and idle cycles read as zero
      next_read_data = `ZERO_WORD;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      read_data <= `ZERO_WORD;
      read_valid <= 1'b0;
    end else begin
      read_data <= next_read_data;
      read_valid <= next_read_valid;
    end
  end

  assign cfg_read_data = read_data;
  assign cfg_read_valid = read_valid;
  assign error_flags = flags;
endmodule
`default_nettype wire

// ---- verif/aer_checker.sv ----
// assertions on the error capability register ports
`timescale 1ns/1ps
`default_nettype none
module aer_checker
  import aer_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_read,
  input wire logic cfg_write,
  input wire dword_index_type cfg_index,
  input wire word_type cfg_write_data,
  input wire logic [3:0] cfg_byte_enable,
  input wire word_type cfg_read_data,
  input wire logic cfg_read_valid,
  input wire logic err_poisoned,
  input wire logic err_link_protocol,
  input wire word_type error_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // clear of the poisoned flag with no fresh error racing it
  sequence clear_poison;
    cfg_write && cfg_index == 10'h001 && cfg_byte_enable[1] && cfg_write_data[12] && !err_poisoned;
  endsequence
  read_answer_a: assert property (cfg_read |=> cfg_read_valid) else $error("no read answer");
  read_quiet_a: assert property (!cfg_read |=> !cfg_read_valid) else $error("stray answer");
  header_value_a: assert property (cfg_read && cfg_index == 10'h000 |=>
    cfg_read_data == 32'h0001_0001) else $error("bad header");
  unmapped_zero_a: assert property (cfg_read && cfg_index > 10'h001 |=>
    cfg_read_data == 32'h0) else $error("unmapped not zero");
  flag_shape_a: assert property ((error_flags & ~32'h001F_F030) == 32'h0) else $error("bad bit");
  poison_set_a: assert property (err_poisoned |=> error_flags[12]) else $error("no set");
  link_set_a: assert property (err_link_protocol |=> error_flags[4]) else $error("no set");
  poison_clear_a: assert property (clear_poison |=> !error_flags[12]) else $error("no clear");
  poison_hold_a: assert property (error_flags[12] && !cfg_write |=> error_flags[12])
    else $error("flag lost");
  no_spurious_a: assert property (!error_flags[12] && !err_poisoned |=> !error_flags[12])
    else $error("flag rose");
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the error capability registers
`timescale 1ns/1ps
`default_nettype none
module testbench
  import aer_pkg::*;
;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH %0t got %h want %h", $time, a, b); end end
  localparam word_type IMPL = 32'h001F_F030;
  logic clk = 0, reset = 1, cfg_read = 0, cfg_write = 0;
  dword_index_type cfg_index = 10'h000;
  word_type cfg_write_data = 32'h0, cfg_read_data, error_flags, flags = 32'h0, clr;
  logic [3:0] cfg_byte_enable = 4'h0;
  logic cfg_read_valid;
  logic [10:0] err = 11'h000;
  word_type exp_q[$];
  int miscompares = 0, num_checks = 0;
  integer seed = 43196;
  word_type want;
  always #25 clk = ~clk;
  adv_error_cap_uncorr_status i_dut (.clk(clk), .reset(reset), .cfg_read(cfg_read),
    .cfg_write(cfg_write), .cfg_index(cfg_index), .cfg_write_data(cfg_write_data),
    .cfg_byte_enable(cfg_byte_enable), .cfg_read_data(cfg_read_data),
    .cfg_read_valid(cfg_read_valid), .err_link_protocol(err[0]), .err_link_loss(err[1]),
    .err_poisoned(err[2]), .err_flow_control(err[3]), .err_cpl_timeout(err[4]),
    .err_completer_abort(err[5]), .err_unexpected_cpl(err[6]), .err_rx_overflow(err[7]),
    .err_malformed(err[8]), .err_crc_fail(err[9]), .err_unsupported(err[10]),
    .error_flags(error_flags));
  // bit positions of the error inputs, in port order
  function automatic word_type spread(input logic [10:0] e);
    spread = {11'h0, e[10], e[9], e[8], e[7], e[6], e[5], e[4], e[3], e[2], 6'h0, e[1], e[0], 4'h0};
  endfunction
  task automatic rd(input dword_index_type idx, input word_type exp);
    @(negedge clk);
    cfg_write = 0;
    err = 11'h000;
    cfg_read = 1;
    cfg_index = idx;
    exp_q.push_back(exp);
    @(negedge clk);
    cfg_read = 0;
  endtask
  // write plus detector pulses in one cycle; same-cycle set wins over clear
  task automatic wr(input dword_index_type idx, input word_type d, input logic [3:0] be,
      input logic [10:0] e);
    @(negedge clk);
    cfg_write = 1;
    cfg_index = idx;
    cfg_write_data = d;
    cfg_byte_enable = be;
    err = e;
    clr = (idx == 10'h001) ? d & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} : 32'h0;
    flags = ((flags & ~clr) | spread(e)) & IMPL;
  endtask
  always @(negedge clk) if (cfg_read_valid === 1'b1) begin
    if (exp_q.size() == 0) `CHK(1'b0, 1'b1)
    else begin
      want = exp_q.pop_front();
      `CHK(cfg_read_data, want)
    end
    `CHK(error_flags, flags)
  end
  task automatic conclude;
    `CHK(exp_q.size(), 0)
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (10) @(negedge clk);
    reset = 0;
    rd(10'h000, 32'h0001_0001);
    rd(10'h001, 32'h0);
    wr(10'h000, 32'hFFFF_FFFF, 4'hF, 11'h7FF);
    rd(10'h000, 32'h0001_0001);
    rd(10'h001, IMPL);
    rd(10'h3FF, 32'h0);
    wr(10'h001, 32'h0000_1000, 4'hD, 11'h000);
    rd(10'h001, IMPL);
    wr(10'h001, 32'hFFFF_FFFF, 4'hF, 11'h004);
    rd(10'h001, flags);
    repeat (60) begin
      wr(10'h001, $random(seed), 4'($random(seed)), 11'($random(seed)));
      rd(10'h001, flags);
    end
    wr(10'h000, 32'h0, 4'h0, 11'h7FF);
    rd(10'h001, IMPL);
    @(negedge clk);
    reset = 1;
    flags = 32'h0;
    repeat (2) @(negedge clk);
    reset = 0;
    rd(10'h001, 32'h0);
    rd(10'h000, 32'h0001_0001);
    repeat (3) @(negedge clk);
    conclude();
  end
endmodule
bind adv_error_cap_uncorr_status aer_checker i_chk (.*);
`default_nettype wire
